// [shared/ssr_pkg.sv]
// shared constants and helpers for the synthesizer serial register link
package ssr_pkg;
  localparam int WORD_W = 32;
  localparam int NUM_REGS = 6;
  localparam int SYNC_W = 3;
  localparam int CNT_W = 8;
  localparam int BIT_W = 5;

  // register select codes in bits 2:0
  localparam int SEL_MSB = 2;
  localparam logic [2:0] SEL_DIV = 3'h0;
  localparam logic [2:0] SEL_PHASE = 3'h1;
  localparam logic [2:0] SEL_NOISE = 3'h2;
  localparam logic [2:0] SEL_CLKDIV = 3'h3;
  localparam logic [2:0] SEL_OUTPUT = 3'h4;
  localparam logic [2:0] SEL_LOCK = 3'h5;

  // field positions
  localparam int INT_MSB = 30;
  localparam int INT_LSB = 15;
  localparam int NUMER_MSB = 14;
  localparam int NUMER_LSB = 3;
  localparam int MODULUS_MSB = 14;
  localparam int MODULUS_LSB = 3;
  localparam int PRESC_BIT = 27;
  localparam int DBUF_EN_BIT = 13;
  localparam int WORD_MSB = 31;

  // shadowed bit masks
  localparam logic [31:0] SHADOW_MASK_R1 = 32'h07FF_FFF8;
  localparam logic [31:0] SHADOW_MASK_R2 = 32'h03FF_DE00;
  localparam logic [31:0] ODIV_MASK = 32'h0070_0000;

  // reserved handling: bits kept from software, bits forced high
  localparam logic [5:0][31:0] KEEP_MASK = {
    32'h00C0_0007, 32'h00FF_FFFF, 32'h00E5_FFFF,
    32'h7FFF_FFFF, 32'h1FFF_FFFF, 32'h7FFF_FFFF};
  localparam logic [5:0][31:0] FORCE_ONES = {
    32'h0018_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  // integer divide limits per prescaler, and fractional modulus reset value
  localparam logic [15:0] INT_MIN_45 = 16'h0017;
  localparam logic [15:0] INT_MIN_89 = 16'h004B;
  localparam logic [11:0] MODULUS_RESET = 12'hFFF;

  // controller apb map
  localparam int APB_AW = 8;
  localparam logic [7:0] ADDR_TX_WORD = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_HALF_PERIOD = 8'h0C;
  localparam int CTRL_GO_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SENT_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam logic [7:0] HALF_PERIOD_RESET = 8'h04;

  function automatic logic [31:0] shadow_merge(input logic [31:0] live,
                                               input logic [31:0] held,
                                               input logic [31:0] mask);
    shadow_merge = (live & ~mask) | (held & mask);
  endfunction

  function automatic logic [31:0] fix_reserved(input logic [31:0] w);
    logic [2:0] sel;
    sel = w[SEL_MSB:0];
    if (sel > SEL_LOCK) begin
      fix_reserved = w;
    end else begin
      fix_reserved = (w & KEEP_MASK[sel]) | FORCE_ONES[sel];
    end
  endfunction
endpackage

// [shared/ssr_link_if.sv]
// three-wire serial programming link between controller and synthesizer
`timescale 1ns/10ps
interface ssr_link_if;
  logic sclk;
  logic sdata;
  logic load_strobe;
  modport host (output sclk, output sdata, output load_strobe);
  modport device (input sclk, input sdata, input load_strobe);
endinterface

// [rtl/ssr_sync.sv]
// two flip-flop synchronizer for asynchronous link inputs
`timescale 1ns/10ps
module ssr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } ssr_sync_state_t;

  ssr_sync_state_t s_reg;
  ssr_sync_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.meta = async_in;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.sync;
endmodule // ssr_sync

// [rtl/ssr_device.sv]
// synthesizer side: serial shift register, latches and shadow staging
// Summary of operation
// - select 000 stores word into register 0
// - integer divide value in bits 30:15
// - 4/5 prescaler integer range 23 to 65535
// - 8/9 prescaler integer at least 75
// - fraction numerator in bits 14:3
// - fraction numerator below fractional modulus
// - shadowed fields activate on register 0 write
// - output divider shadowed only if bit 13
// - shift 32 bits msb first on sclk rise
// - load strobe rise copies into selected latch
// - bits 2:0 select registers 0 to 5
// - register 0 write starts band selection
`timescale 1ns/10ps
module ssr_device (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // serial link
  ssr_link_if.device link,
  // active register contents
  output logic [31:0] divider_integer_fraction,
  output logic [31:0] phase_prescaler_modulus,
  output logic [31:0] noise_mux_reference_pump,
  output logic [31:0] clock_divider_band_mode,
  output logic [31:0] output_feedback_band_clock,
  output logic [31:0] lock_pin_mode,
  // decoded loop values
  output logic [15:0] integer_value,
  output logic [11:0] fraction_numerator,
  output logic [11:0] fractional_modulus,
  output logic prescaler_89,
  // events
  output logic divider_register_write,
  output logic band_select_start
);
  typedef struct packed {
    logic sclk_d;
    logic strobe_d;
    logic [31:0] shift;
    logic [5:0][31:0] act;
    logic [31:0] stage_r1;
    logic [31:0] stage_r2;
    logic [31:0] stage_r4;
    logic odiv_pend;
    logic r0_wr;
    logic band_start;
  } ssr_dev_state_t;

  ssr_dev_state_t s_reg;
  ssr_dev_state_t s_next;
  logic [2:0] link_s;
  logic sclk_s;
  logic data_s;
  logic strobe_s;

  // link pins are asynchronous to sys_clk
  ssr_sync #(.W(ssr_pkg::SYNC_W)) i_ssr_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in({link.sclk, link.sdata, link.load_strobe}),
    .sync_out(link_s)
  );

  assign sclk_s = link_s[2];
  assign data_s = link_s[1];
  assign strobe_s = link_s[0];

  always_comb begin
    logic [31:0] w;
    w = s_reg.shift;
    s_next = s_reg;
    s_next.sclk_d = sclk_s;
    s_next.strobe_d = strobe_s;
    s_next.r0_wr = 1'b0;
    s_next.band_start = 1'b0;
    if (sclk_s && !s_reg.sclk_d) begin
      s_next.shift = {s_reg.shift[ssr_pkg::WORD_MSB-1:0], data_s};
    end
    if (strobe_s && !s_reg.strobe_d) begin
      case (w[ssr_pkg::SEL_MSB:0])
        ssr_pkg::SEL_DIV: begin
          s_next.act[ssr_pkg::SEL_DIV] = w;
          s_next.act[ssr_pkg::SEL_PHASE] = ssr_pkg::shadow_merge(
            s_reg.act[ssr_pkg::SEL_PHASE], s_reg.stage_r1, ssr_pkg::SHADOW_MASK_R1);
          s_next.act[ssr_pkg::SEL_NOISE] = ssr_pkg::shadow_merge(
            s_reg.act[ssr_pkg::SEL_NOISE], s_reg.stage_r2, ssr_pkg::SHADOW_MASK_R2);
          if (s_reg.odiv_pend) begin
            s_next.act[ssr_pkg::SEL_OUTPUT] = ssr_pkg::shadow_merge(
              s_reg.act[ssr_pkg::SEL_OUTPUT], s_reg.stage_r4, ssr_pkg::ODIV_MASK);
          end
          s_next.odiv_pend = 1'b0;
          s_next.r0_wr = 1'b1;
          s_next.band_start = 1'b1;
        end
        ssr_pkg::SEL_PHASE: begin
          s_next.stage_r1 = w;
          s_next.act[ssr_pkg::SEL_PHASE] = ssr_pkg::shadow_merge(
            w, s_reg.act[ssr_pkg::SEL_PHASE], ssr_pkg::SHADOW_MASK_R1);
        end
        ssr_pkg::SEL_NOISE: begin
          s_next.stage_r2 = w;
          s_next.act[ssr_pkg::SEL_NOISE] = ssr_pkg::shadow_merge(
            w, s_reg.act[ssr_pkg::SEL_NOISE], ssr_pkg::SHADOW_MASK_R2);
        end
        ssr_pkg::SEL_CLKDIV: begin
          s_next.act[ssr_pkg::SEL_CLKDIV] = w;
        end
        ssr_pkg::SEL_OUTPUT: begin
          if (s_reg.act[ssr_pkg::SEL_NOISE][ssr_pkg::DBUF_EN_BIT]) begin
            s_next.stage_r4 = w;
            s_next.odiv_pend = 1'b1;
            s_next.act[ssr_pkg::SEL_OUTPUT] = ssr_pkg::shadow_merge(
              w, s_reg.act[ssr_pkg::SEL_OUTPUT], ssr_pkg::ODIV_MASK);
          end else begin
            s_next.odiv_pend = 1'b0;
            s_next.act[ssr_pkg::SEL_OUTPUT] = w;
          end
        end
        ssr_pkg::SEL_LOCK: begin
          s_next.act[ssr_pkg::SEL_LOCK] = w;
        end
        default: begin
          // codes 110 and 111 address nothing
          s_next.shift = s_reg.shift;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign divider_integer_fraction = s_reg.act[ssr_pkg::SEL_DIV];
  assign phase_prescaler_modulus = s_reg.act[ssr_pkg::SEL_PHASE];
  assign noise_mux_reference_pump = s_reg.act[ssr_pkg::SEL_NOISE];
  assign clock_divider_band_mode = s_reg.act[ssr_pkg::SEL_CLKDIV];
  assign output_feedback_band_clock = s_reg.act[ssr_pkg::SEL_OUTPUT];
  assign lock_pin_mode = s_reg.act[ssr_pkg::SEL_LOCK];
  assign integer_value = s_reg.act[ssr_pkg::SEL_DIV][ssr_pkg::INT_MSB:ssr_pkg::INT_LSB];
  assign fraction_numerator =
    s_reg.act[ssr_pkg::SEL_DIV][ssr_pkg::NUMER_MSB:ssr_pkg::NUMER_LSB];
  assign fractional_modulus =
    s_reg.act[ssr_pkg::SEL_PHASE][ssr_pkg::MODULUS_MSB:ssr_pkg::MODULUS_LSB];
  assign prescaler_89 = s_reg.act[ssr_pkg::SEL_PHASE][ssr_pkg::PRESC_BIT];
  assign divider_register_write = s_reg.r0_wr;
  assign band_select_start = s_reg.band_start;
endmodule // ssr_device

// [rtl/ssr_host.sv]
// controller side: apb registers driving the serial programming link
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/10ps
module ssr_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  ssr_link_if.host link
);
  typedef enum {H_IDLE, H_LOW, H_HIGH, H_LOAD, H_GAP} ssr_host_st_t;

  typedef struct packed {
    ssr_host_st_t st;
    logic [31:0] tx;
    logic [31:0] word;
    logic [4:0] bitn;
    logic [7:0] cnt;
    logic [7:0] half;
    logic sent;
    logic refused;
    logic presc89;
    logic [11:0] modv;
    logic sclk;
    logic sdo;
    logic strobe;
    logic [31:0] rdata;
    logic err;
  } ssr_host_state_t;

  ssr_host_state_t s_reg;
  ssr_host_state_t s_next;

  function automatic logic [7:0] reload(input logic [7:0] half);
    reload = (half == 8'h00) ? 8'h00 : 8'(half - 8'h01);
  endfunction

  always_comb begin
    logic [31:0] w;
    logic [15:0] intv;
    logic bad;
    logic mapped;
    logic wr;
    w = ssr_pkg::fix_reserved(s_reg.tx);
    intv = w[ssr_pkg::INT_MSB:ssr_pkg::INT_LSB];
    bad = 1'b0;
    mapped = (paddr == ssr_pkg::ADDR_TX_WORD) || (paddr == ssr_pkg::ADDR_CTRL) ||
             (paddr == ssr_pkg::ADDR_STATUS) || (paddr == ssr_pkg::ADDR_HALF_PERIOD);
    wr = psel && penable && pwrite && mapped;
    s_next = s_reg;
    // setup phase prepares the answer for the access phase
    if (psel && !penable) begin
      s_next.err = !mapped;
      case (paddr)
        ssr_pkg::ADDR_TX_WORD: s_next.rdata = s_reg.tx;
        ssr_pkg::ADDR_STATUS: s_next.rdata = {29'h0000_0000, s_reg.refused, s_reg.sent,
                                              s_reg.st != H_IDLE};
        ssr_pkg::ADDR_HALF_PERIOD: s_next.rdata = {24'h00_0000, s_reg.half};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
    if (wr && paddr == ssr_pkg::ADDR_TX_WORD) begin
      s_next.tx = pwdata;
    end
    if (wr && paddr == ssr_pkg::ADDR_HALF_PERIOD) begin
      s_next.half = pwdata[7:0];
    end
    // write one clears; a later set in this cycle wins
    if (wr && paddr == ssr_pkg::ADDR_STATUS) begin
      if (pwdata[ssr_pkg::STAT_SENT_BIT]) begin
        s_next.sent = 1'b0;
      end
      if (pwdata[ssr_pkg::STAT_REFUSED_BIT]) begin
        s_next.refused = 1'b0;
      end
    end
    case (s_reg.st)
      H_IDLE: begin
        if (wr && paddr == ssr_pkg::ADDR_CTRL && pwdata[ssr_pkg::CTRL_GO_BIT]) begin
          if (w[ssr_pkg::SEL_MSB:0] == ssr_pkg::SEL_DIV) begin
            bad = s_reg.presc89 ? (intv < ssr_pkg::INT_MIN_89) : (intv < ssr_pkg::INT_MIN_45);
            if (w[ssr_pkg::NUMER_MSB:ssr_pkg::NUMER_LSB] >= s_reg.modv) begin
              bad = 1'b1;
            end
          end
          if (bad) begin
            s_next.refused = 1'b1;
          end else begin
            s_next.word = w;
            // select code travels in low bits
            if (w[ssr_pkg::SEL_MSB:0] == ssr_pkg::SEL_PHASE) begin
              s_next.presc89 = w[ssr_pkg::PRESC_BIT];
              s_next.modv = w[ssr_pkg::MODULUS_MSB:ssr_pkg::MODULUS_LSB];
            end
            s_next.bitn = 5'h1F;
            s_next.sdo = w[ssr_pkg::WORD_MSB];
            s_next.sclk = 1'b0;
            s_next.cnt = reload(s_reg.half);
            s_next.st = H_LOW;
          end
        end
      end
      H_LOW: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.sclk = 1'b1;
          s_next.cnt = reload(s_reg.half);
          s_next.st = H_HIGH;
        end else begin
          s_next.cnt = 8'(s_reg.cnt - 8'h01);
        end
      end
      H_HIGH: begin
        if (s_reg.cnt == 8'h00) begin
          // data changes on the falling edge, far from the sampling edge
          s_next.sclk = 1'b0;
          s_next.cnt = reload(s_reg.half);
          if (s_reg.bitn == 5'h00) begin
            s_next.st = H_LOAD;
          end else begin
            s_next.bitn = 5'(s_reg.bitn - 5'h01);
            s_next.sdo = s_reg.word[5'(s_reg.bitn - 5'h01)];
            s_next.st = H_LOW;
          end
        end else begin
          s_next.cnt = 8'(s_reg.cnt - 8'h01);
        end
      end
      H_LOAD: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.strobe = 1'b1;
          s_next.cnt = reload(s_reg.half);
          s_next.st = H_GAP;
        end else begin
          s_next.cnt = 8'(s_reg.cnt - 8'h01);
        end
      end
      H_GAP: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.strobe = 1'b0;
          s_next.sent = 1'b1;
          s_next.st = H_IDLE;
        end else begin
          s_next.cnt = 8'(s_reg.cnt - 8'h01);
        end
      end
      default: begin
        s_next.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.st <= H_IDLE;
      s_reg.half <= ssr_pkg::HALF_PERIOD_RESET;
      s_reg.modv <= ssr_pkg::MODULUS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pready = 1'b1;
  assign prdata = s_reg.rdata;
  assign pslverr = s_reg.err;
  assign link.sclk = s_reg.sclk;
  assign link.sdata = s_reg.sdo;
  assign link.load_strobe = s_reg.strobe;
endmodule // ssr_host

// [verification/ssr_link_sva.sv]
// link checker for the synthesizer serial register map
`timescale 1ns/10ps
module ssr_link_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // link wires
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe,
  // device events
  input wire logic divider_register_write,
  input wire logic band_select_start
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic sclk_reg;
  logic [31:0] sh_reg;
  logic [6:0] cnt_reg;

  // mirror of the device shift register, counts rises since last strobe
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sclk_reg <= 1'b0;
      sh_reg <= 32'h0000_0000;
      cnt_reg <= 7'h00;
    end else begin
      sclk_reg <= sclk;
      if (load_strobe) begin
        cnt_reg <= 7'h00;
      end else if (sclk && !sclk_reg) begin
        cnt_reg <= cnt_reg + 7'h01;
      end
      if (sclk && !sclk_reg) begin
        sh_reg <= {sh_reg[30:0], sdata};
      end
    end
  end

  sequence s_sel0_load;
    $rose(load_strobe) && sh_reg[2:0] == 3'h0;
  endsequence
  sequence s_other_load;
    $rose(load_strobe) && sh_reg[2:0] != 3'h0;
  endsequence
  // widths assume the half period left at its reset value of 4
  sequence s_strobe_high;
    load_strobe[*4] ##1 !load_strobe;
  endsequence

  a_count_thirtytwo: assert property ($rose(load_strobe) |-> cnt_reg == 7'd32)
    else $error("strobe not after exactly 32 clock rises");
  a_sdata_hold: assert property (sclk && sclk_reg |-> $stable(sdata))
    else $error("data moved while serial clock high");
  a_sclk_high_half: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("serial clock high phase wrong width");
  a_strobe_width: assert property ($rose(load_strobe) |-> s_strobe_high)
    else $error("load strobe wrong width");
  a_strobe_clk_low: assert property (load_strobe |-> !sclk)
    else $error("serial clock high during strobe");
  a_reg0_pulse: assert property (s_sel0_load |-> ##[3:5] divider_register_write)
    else $error("no divider write pulse after select 0 load");
  a_no_stray_pulse: assert property (s_other_load |-> !divider_register_write[*8])
    else $error("divider write pulse after other select");
  a_pulse_cause: assert property (divider_register_write |->
    $past(load_strobe, 3) && sh_reg[2:0] == 3'h0)
    else $error("divider write pulse without select 0 load");
  a_pulse_single: assert property (divider_register_write |=> !divider_register_write)
    else $error("divider write pulse longer than one cycle");
  a_band_with_write: assert property (band_select_start == divider_register_write)
    else $error("band select start not with divider write");
endmodule // ssr_link_sva

// [verification/test_synth_serial_register_map.sv]
// self-checking bench joining controller and synthesizer ends
`timescale 1ns/10ps
module test_synth_serial_register_map;
  logic sys_clk;
  logic sys_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] act0, act1, act2, act3, act4, act5;
  logic [15:0] int_val;
  logic [11:0] numer;
  logic [11:0] modulus;
  logic presc;
  logic dwr;
  logic bss;
  int bad_count = 0;
  int total_checks = 0;
  int pulses = 0;

  ssr_link_if link ();
  ssr_host i_ssr_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  ssr_device i_ssr_device (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
    .divider_integer_fraction(act0), .phase_prescaler_modulus(act1),
    .noise_mux_reference_pump(act2), .clock_divider_band_mode(act3),
    .output_feedback_band_clock(act4), .lock_pin_mode(act5), .integer_value(int_val),
    .fraction_numerator(numer), .fractional_modulus(modulus),
    .prescaler_89(presc), .divider_register_write(dwr), .band_select_start(bss));
  ssr_link_sva i_ssr_link_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .sclk(link.sclk), .sdata(link.sdata), .load_strobe(link.load_strobe),
    .divider_register_write(dwr), .band_select_start(bss));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (dwr === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      results();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] w0(input int n, input int f);
    w0 = {1'b0, n[15:0], f[11:0], 3'h0};
  endfunction

  // loads a word, waits for sent or refused, and judges the refusal flag
  task automatic send(input logic [31:0] w, input logic refused);
    logic [31:0] q;
    logic e;
    int n;
    apb(1'b1, ssr_pkg::ADDR_TX_WORD, w, q, e);
    apb(1'b1, ssr_pkg::ADDR_CTRL, 32'h0000_0001, q, e);
    apb(1'b0, ssr_pkg::ADDR_STATUS, 32'h0000_0000, q, e);
    check_word({31'h0, q[ssr_pkg::STAT_BUSY_BIT]}, {31'h0, ~refused});
    n = 0;
    do begin
      apb(1'b0, ssr_pkg::ADDR_STATUS, 32'h0000_0000, q, e);
      n++;
    end while (q[2:1] === 2'b00 && n < 400);
    if (n >= 400) begin
      bad_count++;
      results();
    end
    check_word({31'h0, q[ssr_pkg::STAT_REFUSED_BIT]}, {31'h0, refused});
    apb(1'b1, ssr_pkg::ADDR_STATUS, 32'h0000_0006, q, e);
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic t_map();
    logic [31:0] q;
    logic e;
    apb(1'b0, ssr_pkg::ADDR_HALF_PERIOD, 32'h0, q, e);
    check_word(q, 32'h0000_0004);
    apb(1'b1, ssr_pkg::ADDR_HALF_PERIOD, 32'h0000_0002, q, e);
    apb(1'b0, ssr_pkg::ADDR_HALF_PERIOD, 32'h0, q, e);
    check_word(q, 32'h0000_0002);
    // link checks assume the reset half period, so put it back
    apb(1'b1, ssr_pkg::ADDR_HALF_PERIOD, 32'h0000_0004, q, e);
    apb(1'b0, ssr_pkg::ADDR_HALF_PERIOD, 32'h0, q, e);
    check_word(q, 32'h0000_0004);
    apb(1'b0, 8'h10, 32'h0, q, e);
    check_word({q[30:0], e}, 32'h0000_0001);
    $display("map test done");
  endtask

  task automatic t_reg0();
    int p;
    p = pulses;
    send(w0(23, 5), 1'b0);
    check_word(act0, 32'h000B_8028);
    check_word({16'h0, int_val}, 32'd23);
    check_word({20'h0, numer}, 32'd5);
    check_word(pulses, p + 1);
    send(w0(22, 5), 1'b1);
    check_word(act0, 32'h000B_8028);
    check_word(pulses, p + 1);
    $display("register 0 test done");
  endtask

  task automatic t_regs();
    int p;
    send(32'hFFFF_FFFB, 1'b0);
    send(32'hFF8F_F00C, 1'b0);
    send(32'hFFFF_FFFD, 1'b0);
    check_word(act3, 32'h00E5_FFFB);
    check_word(act4, 32'h008F_F00C);
    check_word(act5, 32'h00D8_0005);
    p = pulses;
    send(32'h0000_0006, 1'b0);
    check_word(act3 ^ act4 ^ act5 ^ act0, 32'h00B9_8FDA);
    check_word(pulses, p);
    $display("select test done");
  endtask

  task automatic t_shadow();
    send(32'h0000_0081, 1'b0);
    check_word(act1, 32'h0000_0001);
    check_word({20'h0, modulus}, 32'h0);
    send(w0(30, 16), 1'b1);
    send(w0(30, 15), 1'b0);
    check_word(act1, 32'h0000_0081);
    check_word({20'h0, modulus}, 32'd16);
    send(32'h0800_0081, 1'b0);
    check_word({31'h0, presc}, 32'h1);
    send(w0(74, 0), 1'b1);
    send(w0(75, 0), 1'b0);
    check_word({16'h0, int_val}, 32'd75);
    $display("shadow test done");
  endtask

  task automatic t_odiv();
    send(32'h0000_2002, 1'b0);
    check_word(act2, 32'h0000_2002);
    send(32'h0030_0004, 1'b0);
    check_word(act4, 32'h0000_0004);
    send(w0(80, 1), 1'b0);
    check_word(act4, 32'h0030_0004);
    send(32'h0000_0002, 1'b0);
    send(32'h0050_0004, 1'b0);
    check_word(act4, 32'h0050_0004);
    $display("divider select test done");
  endtask

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_map();
    t_reg0();
    t_regs();
    t_shadow();
    t_odiv();
    results();
  end
endmodule // test_synth_serial_register_map
